// >>> dv/spi_host.sv
// Purpose: serial bus master model driving the register link
// Assumes: serial clock idles low, 125 ns bit period, MSB first
// Notes: the data line is inverted while deselected, never held
module spi_host (
	output strap_pin_pkg::spi_pins_t o_spi,
	input wire logic i_sdo
);
	timeunit 1ns;
	timeprecision 100ps;
	initial o_spi = strap_pin_pkg::spi_pins_t'(4'h8);
	////////////////////////////////////////////////////////////////
	// select held, master clocks
	task automatic xfer(input logic ph, input logic r, input logic [6:0] a,
		input logic [7:0] wd, output logic [7:0] q);
		logic [15:0] f;
		f = {r, a, wd};
		q = 8'h00;
		o_spi.capture_edge_select = ph;
		o_spi.cs_n = 1'b0;
		#125;
		// Trailing capture: data moves on the leading edge, never at the capture edge
		for (int i = 15; i >= 0; i--) begin
			if (!ph) o_spi.sdi = f[i];
			#62.5;
			o_spi.sclk = 1'b1;
			if (ph) o_spi.sdi = f[i];
			if (!ph && i < 8) q[i] = i_sdo;
			#62.5;
			o_spi.sclk = 1'b0;
			if (ph && i < 8) q[i] = i_sdo;
		end
		// Hold select past the last capture so the write lands
		#125;
		o_spi.cs_n = 1'b1;
		o_spi.sdi = ~o_spi.sdi;
		#125;
	endtask
endmodule // spi_host

// >>> dv/strap_pin_block_bench.sv
// Purpose: self-checking bench for the strap and status pin block
// Assumes: 100 MHz core clock, serial link driven by the host model
// Notes: shared pin levels resolve from design enables and bench levels
module strap_pin_block_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic i_core_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [6:0] i_addr = 7'h00;
	logic [7:0] i_wdata = 8'h00;
	logic [7:0] q;
	logic sw = 1'b0, sfail = 1'b0, lck = 1'b0, pend = 1'b0, act = 1'b0;
	logic [2:0] se = 3'h0;
	logic [3:0] gp = 4'h0;
	int n_fail = 0;
	int checked = 0;
	strap_pin_pkg::pin_drive_t o_refail_pin, o_lock_pin, o_irq_pin;
	strap_pin_pkg::spi_pins_t spi;
	strap_pin_pkg::ctrl_t o_ctrl;
	strap_pin_pkg::strap_t o_strap;
	logic [7:0] o_rdata;
	logic [3:0] o_gp_pin, o_gp_pin_oe;
	logic o_sdo, o_input_pair_select;
	wire logic fail_w = o_refail_pin.oe ? o_refail_pin.out : se[1];
	wire logic lock_w = o_lock_pin.oe ? o_lock_pin.out : se[2];
	wire logic [3:0] gp_w = (o_gp_pin_oe & o_gp_pin) | (~o_gp_pin_oe & gp);
	initial forever #5 i_core_clk = ~i_core_clk;
	strap_pin_block u_dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_fast_source_switch_in(sw), .i_se_strap_b0(se[0]), .i_refail_pin(fail_w),
		.o_refail_pin(o_refail_pin), .i_lock_pin(lock_w), .o_lock_pin(o_lock_pin),
		.i_gp_pin(gp_w), .o_gp_pin(o_gp_pin), .o_gp_pin_oe(o_gp_pin_oe),
		.o_irq_pin(o_irq_pin), .i_spi(spi), .o_sdo(o_sdo),
		.i_reference_failure_status(sfail), .i_dpll_locked(lck), .i_irq_pending(pend),
		.i_ref_activity(act), .o_input_pair_select(o_input_pair_select),
		.o_ctrl(o_ctrl), .o_strap(o_strap));
	spi_host u_host (.o_spi(spi), .i_sdo(o_sdo));
	////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
		checked++;
		if (s !== e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge i_core_clk);
		#1;
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge i_core_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rc(input logic [6:0] a, input logic [7:0] e);
		logic [7:0] d;
		@(posedge i_core_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		#1 d = o_rdata;
		chk("rdata", d, e);
	endtask
	task automatic setp(input logic s, input logic f, input logic l, input logic p,
		input logic a);
		@(posedge i_core_clk);
		sw <= s;
		sfail <= f;
		lck <= l;
		pend <= p;
		act <= a;
		tick(5);
	endtask
	////////////////////////////////////////////////////////////////
	// reset held five cycles
	task automatic strap_test(input logic s, input logic [2:0] e, input logic [3:0] g);
		@(posedge i_core_clk);
		sw <= s;
		se <= e;
		gp <= g;
		i_rst_n <= 1'b0;
		repeat (5) @(posedge i_core_clk);
		i_rst_n <= 1'b1;
		#1;
		chk("oe", {o_refail_pin.oe, o_lock_pin.oe, o_irq_pin.oe, o_gp_pin_oe}, 8'h00);
		tick(2);
		chk("strap", o_strap, {g[2:0], e});
		chk("ctrl", o_ctrl, {{3{g[3]}}, 2'b00, s});
		rc(strap_pin_pkg::ADDR_GP_CTRL, 8'h00);
		rc(strap_pin_pkg::ADDR_INT_CTRL, 8'h00);
		wr(strap_pin_pkg::ADDR_STRAP, 8'hff);
		rc(strap_pin_pkg::ADDR_STRAP, {2'b00, g[2:0], e});
		rc(7'h7f, 8'h00);
		@(posedge i_core_clk);
		sw <= ~s;
		se <= ~e;
		gp <= ~g;
		tick(6);
		chk("held", o_strap, {g[2:0], e});
		chk("held", o_ctrl, {{3{g[3]}}, 2'b00, s});
		$display("strap test done");
	endtask
	task automatic pin_test;
		wr(strap_pin_pkg::ADDR_CTRL, 8'h07);
		setp(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
		chk("pair", o_input_pair_select, 8'h01);
		chk("fail", o_refail_pin, 8'h03);
		chk("lock", o_lock_pin, 8'h03);
		rc(strap_pin_pkg::ADDR_STATUS, 8'h07);
		setp(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		chk("pair", o_input_pair_select, 8'h00);
		chk("fail", o_refail_pin, 8'h01);
		chk("lock", o_lock_pin, 8'h01);
		wr(strap_pin_pkg::ADDR_CTRL, 8'h00);
		setp(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
		chk("pair", o_input_pair_select, 8'h00);
		chk("fail", o_refail_pin.oe, 8'h00);
		chk("lock", o_lock_pin, 8'h01);
		$display("pin test done");
	endtask
	task automatic gp_test;
		wr(strap_pin_pkg::ADDR_GP_CTRL, 8'h53);
		@(posedge i_core_clk);
		gp <= 4'hc;
		tick(5);
		chk("gp_oe", o_gp_pin_oe, 8'h03);
		chk("gp_out", o_gp_pin & o_gp_pin_oe, 8'h01);
		rc(strap_pin_pkg::ADDR_GP_STATE, 8'h0d);
		rc(strap_pin_pkg::ADDR_GP_CTRL, 8'h53);
		$display("gp test done");
	endtask
	task automatic irq1(input logic [7:0] c, input logic p, input logic a,
		input logic [1:0] e);
		wr(strap_pin_pkg::ADDR_INT_CTRL, c);
		setp(sw, sfail, lck, p, a);
		// A floating pin has no meaningful level, only its enable counts
		chk("irq", o_irq_pin & {e[0], 1'b1}, e);
	endtask
	task automatic irq_test;
		irq1(8'h00, 1'b1, 1'b0, 2'b01);
		irq1(8'h00, 1'b0, 1'b0, 2'b11);
		irq1(8'h02, 1'b1, 1'b0, 2'b11);
		irq1(8'h02, 1'b0, 1'b0, 2'b01);
		irq1(8'h04, 1'b1, 1'b0, 2'b01);
		irq1(8'h04, 1'b0, 1'b0, 2'b00);
		irq1(8'h01, 1'b0, 1'b1, 2'b11);
		irq1(8'h01, 1'b1, 1'b0, 2'b01);
		irq1(8'h18, 1'b0, 1'b0, 2'b11);
		irq1(8'h08, 1'b1, 1'b0, 2'b01);
		$display("irq test done");
	endtask
	task automatic spi_test;
		logic [7:0] v;
		for (int ph = 0; ph < 2; ph++) begin
			v = ph[0] ? 8'h5c : 8'ha3;
			u_host.xfer(ph[0], 1'b0, strap_pin_pkg::ADDR_GP_CTRL, v, q);
			tick(2);
			rc(strap_pin_pkg::ADDR_GP_CTRL, v);
			wr(strap_pin_pkg::ADDR_GP_CTRL, ~v);
			u_host.xfer(ph[0], 1'b1, strap_pin_pkg::ADDR_GP_CTRL, 8'h00, q);
			chk("sdo", q, ~v);
		end
		$display("serial test done");
	endtask
	////////////////////////////////////////////////////////////////
	task automatic results;
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		strap_test(1'b1, 3'h5, 4'ha);
		pin_test();
		gp_test();
		irq_test();
		spi_test();
		strap_test(1'b0, 3'h2, 4'h5);
		results();
	end
	// Whole run needs about 11 us; far beyond that means a hang
	initial begin
		#500000;
		n_fail++;
		results();
	end
endmodule // strap_pin_block_bench

// >>> inc/strap_pin_pkg.sv
// Purpose: constants and types for the reset strap and status pin block
// Assumes: one 100 MHz core clock, byte-wide register port, 7-bit register index
// Notes: register indices are shared by the local port and the serial link
// Behaviour
// - Reset low returns every register but the synchronisers to defaults
// - Source switch strap loads external switch enable
// - Enabled source switch picks input pair
// - Three straps give single-ended output code
// - Three straps give differential output code
// - Failure pin mirrors status or floats
// - Lock pin shows lock or drives low
// - Four GP pins: direction, value, status
// - Rate strap sets family and digital bits
// - Interrupt pin: request or reference activity
// - Interrupt polarity, open drain, GP output
// - Master clocks, sends serial in; device answers
// - Phase input picks leading or trailing edge
package strap_pin_pkg;

	localparam logic [6:0] ADDR_CTRL = 7'h00;
	localparam logic [6:0] ADDR_STRAP = 7'h01;
	localparam logic [6:0] ADDR_GP_CTRL = 7'h02;
	localparam logic [6:0] ADDR_GP_STATE = 7'h03;
	localparam logic [6:0] ADDR_INT_CTRL = 7'h04;
	localparam logic [6:0] ADDR_STATUS = 7'h05;

	// Controller side figure, listed for the bench
	localparam int RST_MIN_OSC_CYCLES = 2;
	// Last bit index of the command byte and of the data byte
	localparam logic [2:0] LAST_BIT = 3'h7;

	typedef struct packed {
		logic dig2_family;
		logic dig1_family;
		logic rate_family_select;
		logic lock_pin_enable;
		logic reference_failure_pin_enable;
		logic external_switch_enable;
	} ctrl_t;

	typedef struct packed {
		logic [2:0] diff_code;
		logic [2:0] se_code;
	} strap_t;

	typedef struct packed {
		logic [3:0] out_value;
		logic [3:0] direction;
	} gp_ctrl_t;

	typedef struct packed {
		logic gpo_value;
		logic gpo_mode;
		logic open_drain;
		logic active_high;
		logic ref_loss_mode;
	} int_ctrl_t;

	typedef struct packed {
		logic out;
		logic oe;
	} pin_drive_t;

	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic sdi;
		logic capture_edge_select;
	} spi_pins_t;

	typedef struct packed {
		spi_pins_t spi;
		logic fast_source_switch_in;
		logic se_strap_b0;
		logic refail_pin;
		logic lock_pin;
		logic [3:0] gp_pin;
	} pin_sample_t;

	typedef enum logic [2:0] {
		SPI_IDLE = 3'h1,
		SPI_CMD = 3'h2,
		SPI_DATA = 3'h4
	} spi_state_t;

	localparam ctrl_t CTRL_RST = ctrl_t'(6'h00);
	localparam strap_t STRAP_RST = strap_t'(6'h00);
	localparam gp_ctrl_t GP_CTRL_RST = gp_ctrl_t'(8'h00);
	localparam int_ctrl_t INT_CTRL_RST = int_ctrl_t'(5'h00);

endpackage

// >>> verilog/strap_pin_block.sv
// Purpose: strap capture at reset release, shared status pins, GP pins, serial register link
// Assumes: pins and serial link are asynchronous and pass two flip-flops
// Notes: serial frame is read flag, 7-bit index, 8 data bits, MSB first, clock idles low
module strap_pin_block (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic [6:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	input wire logic i_fast_source_switch_in,
	input wire logic i_se_strap_b0,
	input wire logic i_refail_pin,
	output strap_pin_pkg::pin_drive_t o_refail_pin,
	input wire logic i_lock_pin,
	output strap_pin_pkg::pin_drive_t o_lock_pin,
	input wire logic [3:0] i_gp_pin,
	output logic [3:0] o_gp_pin,
	output logic [3:0] o_gp_pin_oe,
	output strap_pin_pkg::pin_drive_t o_irq_pin,
	input wire strap_pin_pkg::spi_pins_t i_spi,
	output logic o_sdo,
	input wire logic i_reference_failure_status,
	input wire logic i_dpll_locked,
	input wire logic i_irq_pending,
	input wire logic i_ref_activity,
	output logic o_input_pair_select,
	output strap_pin_pkg::ctrl_t o_ctrl,
	output strap_pin_pkg::strap_t o_strap
);

	typedef struct packed {
		strap_pin_pkg::pin_sample_t s1;
		strap_pin_pkg::pin_sample_t s2;
		logic sclk_d;
		logic in_reset;
		logic live;
		strap_pin_pkg::ctrl_t ctrl;
		strap_pin_pkg::strap_t strap;
		strap_pin_pkg::gp_ctrl_t gp;
		strap_pin_pkg::int_ctrl_t ic;
		strap_pin_pkg::spi_state_t spi;
		logic [2:0] bit_cnt;
		logic rw;
		logic [6:0] addr;
		logic [7:0] sh_in;
		logic [7:0] sh_out;
		logic sdo;
		logic [7:0] rdata;
		logic pair_sel;
		strap_pin_pkg::pin_drive_t refail;
		strap_pin_pkg::pin_drive_t lock;
		strap_pin_pkg::pin_drive_t irq;
		logic [3:0] gp_out;
		logic [3:0] gp_oe;
	} state_t;

	state_t st;
	state_t next_st;
	strap_pin_pkg::pin_sample_t pins;
	logic sclk_rise;
	logic sclk_fall;
	logic cap_edge;
	logic launch_edge;
	logic irq_level;

	////////////////////////////////////////////////////////////////////////////////
	// Register access shared by the local port and the serial link

	function automatic logic [7:0] reg_read(input state_t s, input logic [6:0] a);
		logic [7:0] d;
		d = 8'h00;
		case (a)
			strap_pin_pkg::ADDR_CTRL: d = {2'h0, s.ctrl};
			strap_pin_pkg::ADDR_STRAP: d = {2'h0, s.strap};
			strap_pin_pkg::ADDR_GP_CTRL: d = s.gp;
			strap_pin_pkg::ADDR_GP_STATE: d = {4'h0, s.s2.gp_pin};
			strap_pin_pkg::ADDR_INT_CTRL: d = {3'h0, s.ic};
			strap_pin_pkg::ADDR_STATUS: d = {5'h00, s.s2.fast_source_switch_in,
				i_dpll_locked, i_reference_failure_status};
			default: d = 8'h00;
		endcase
		return d;
	endfunction

	// Strap register is read only, so later pin activity cannot disturb it
	function automatic state_t reg_write(input state_t s, input logic [6:0] a,
		input logic [7:0] d);
		state_t r;
		r = s;
		case (a)
			strap_pin_pkg::ADDR_CTRL: r.ctrl = d[5:0];
			strap_pin_pkg::ADDR_GP_CTRL: r.gp = d;
			strap_pin_pkg::ADDR_INT_CTRL: r.ic = d[4:0];
			default: r = s;
		endcase
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	assign pins = {i_spi, i_fast_source_switch_in, i_se_strap_b0, i_refail_pin, i_lock_pin,
		i_gp_pin};
	assign sclk_rise = st.s2.spi.sclk & ~st.sclk_d;
	assign sclk_fall = ~st.s2.spi.sclk & st.sclk_d;
	assign cap_edge = st.s2.spi.capture_edge_select ? sclk_fall : sclk_rise;
	assign launch_edge = st.s2.spi.capture_edge_select ? sclk_rise : sclk_fall;

	always_comb begin
		next_st = st;
		// Synchronisers keep running through reset so the straps are valid at release
		next_st.s1 = pins;
		next_st.s2 = st.s1;
		next_st.sclk_d = st.s2.spi.sclk;
		next_st.rdata = 8'h00;
		irq_level = 1'b0;
		if (!i_rst_n) begin
			next_st.in_reset = 1'b1;
			next_st.live = 1'b0;
			next_st.ctrl = strap_pin_pkg::CTRL_RST;
			next_st.strap = strap_pin_pkg::STRAP_RST;
			next_st.gp = strap_pin_pkg::GP_CTRL_RST;
			next_st.ic = strap_pin_pkg::INT_CTRL_RST;
			next_st.spi = strap_pin_pkg::SPI_IDLE;
			next_st.bit_cnt = 3'h0;
			next_st.rw = 1'b0;
			next_st.addr = 7'h00;
			next_st.sh_in = 8'h00;
			next_st.sh_out = 8'h00;
			next_st.sdo = 1'b0;
			next_st.pair_sel = 1'b0;
			next_st.refail = 2'h0;
			next_st.lock = 2'h0;
			next_st.irq = 2'h0;
			next_st.gp_out = 4'h0;
			next_st.gp_oe = 4'h0;
		end else begin
			if (st.in_reset) begin
				next_st.in_reset = 1'b0;
				next_st.live = 1'b1;
				next_st.ctrl.external_switch_enable = st.s2.fast_source_switch_in;
				next_st.strap.se_code = {st.s2.lock_pin, st.s2.refail_pin, st.s2.se_strap_b0};
				next_st.strap.diff_code = st.s2.gp_pin[2:0];
				next_st.ctrl.rate_family_select = st.s2.gp_pin[3];
				next_st.ctrl.dig1_family = st.s2.gp_pin[3];
				next_st.ctrl.dig2_family = st.s2.gp_pin[3];
			end

			if (st.s2.spi.cs_n) begin
				next_st.spi = strap_pin_pkg::SPI_IDLE;
				next_st.bit_cnt = 3'h0;
			end else begin
				case (st.spi)
					strap_pin_pkg::SPI_IDLE: begin
						next_st.spi = strap_pin_pkg::SPI_CMD;
						next_st.bit_cnt = 3'h0;
						next_st.sh_out = 8'h00;
					end
					strap_pin_pkg::SPI_CMD: begin
						if (cap_edge) begin
							next_st.sh_in = {st.sh_in[6:0], st.s2.spi.sdi};
							next_st.bit_cnt = st.bit_cnt + 3'h1;
							if (st.bit_cnt == strap_pin_pkg::LAST_BIT) begin
								next_st.rw = st.sh_in[6];
								next_st.addr = {st.sh_in[5:0], st.s2.spi.sdi};
								next_st.sh_out = reg_read(st, {st.sh_in[5:0], st.s2.spi.sdi});
								next_st.spi = strap_pin_pkg::SPI_DATA;
							end
						end
					end
					strap_pin_pkg::SPI_DATA: begin
						if (cap_edge) begin
							next_st.sh_in = {st.sh_in[6:0], st.s2.spi.sdi};
							next_st.bit_cnt = st.bit_cnt + 3'h1;
							if (st.bit_cnt == strap_pin_pkg::LAST_BIT && !st.rw) begin
								next_st = reg_write(next_st, st.addr,
									{st.sh_in[6:0], st.s2.spi.sdi});
							end
						end
						if (launch_edge) begin
							next_st.sdo = st.sh_out[7];
							next_st.sh_out = {st.sh_out[6:0], 1'b0};
						end
					end
					default: next_st.spi = strap_pin_pkg::SPI_IDLE;
				endcase
			end

			// Local port wins a same-cycle clash with a serial write
			if (i_wr) begin
				next_st = reg_write(next_st, i_addr, i_wdata);
			end
			if (i_rd) begin
				next_st.rdata = reg_read(st, i_addr);
			end

			next_st.pair_sel = st.ctrl.external_switch_enable & st.s2.fast_source_switch_in;
			next_st.refail.out = i_reference_failure_status;
			next_st.refail.oe = st.live & st.ctrl.reference_failure_pin_enable;
			next_st.lock.out = st.ctrl.lock_pin_enable & i_dpll_locked;
			next_st.lock.oe = st.live;
			next_st.gp_out = st.gp.out_value;
			next_st.gp_oe = st.live ? st.gp.direction : 4'h0;
			if (st.ic.ref_loss_mode) begin
				irq_level = i_ref_activity;
			end else if (st.ic.gpo_mode) begin
				irq_level = st.ic.gpo_value;
			end else begin
				irq_level = st.ic.active_high ? i_irq_pending : ~i_irq_pending;
			end
			if (st.ic.open_drain && !st.ic.ref_loss_mode) begin
				next_st.irq.out = 1'b0;
				next_st.irq.oe = st.live & ~irq_level;
			end else begin
				next_st.irq.out = irq_level;
				next_st.irq.oe = st.live;
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		st <= next_st;
	end

	assign o_rdata = st.rdata;
	assign o_refail_pin = st.refail;
	assign o_lock_pin = st.lock;
	assign o_gp_pin = st.gp_out;
	assign o_gp_pin_oe = st.gp_oe;
	assign o_irq_pin = st.irq;
	assign o_sdo = st.sdo;
	assign o_input_pair_select = st.pair_sel;
	assign o_ctrl = st.ctrl;
	assign o_strap = st.strap;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);

	AST_RESET_QUIET: assert property (disable iff (1'b0) !i_rst_n |=>
		!o_refail_pin.oe && !o_lock_pin.oe && !o_irq_pin.oe && o_gp_pin_oe == 4'h0)
		else $error("pins driven during reset");
	AST_SWITCH_STRAP: assert property (st.in_reset && i_rst_n |=>
		o_ctrl.external_switch_enable == $past(st.s2.fast_source_switch_in) || $past(i_wr))
		else $error("switch strap not captured");
	AST_PAIR_SELECT: assert property (st.live && !o_ctrl.external_switch_enable |=>
		!o_input_pair_select)
		else $error("pair select without enable");
	AST_SE_CODE: assert property (st.in_reset && i_rst_n |=>
		o_strap.se_code == {$past(st.s2.lock_pin), $past(st.s2.refail_pin),
		$past(st.s2.se_strap_b0)})
		else $error("single-ended code wrong");
	AST_DIFF_CODE: assert property (st.in_reset && i_rst_n |=>
		o_strap.diff_code == $past(st.s2.gp_pin[2:0]))
		else $error("differential code wrong");
	AST_REFAIL_PIN: assert property (st.live ##1 st.live |->
		o_refail_pin.oe == $past(o_ctrl.reference_failure_pin_enable))
		else $error("failure pin enable wrong");
	AST_LOCK_LOW: assert property (st.live && !o_ctrl.lock_pin_enable |=>
		o_lock_pin.oe && !o_lock_pin.out)
		else $error("lock pin not low");
	AST_GP_DIR: assert property (st.live ##1 st.live |->
		o_gp_pin_oe == $past(st.gp.direction))
		else $error("GP direction wrong");
	AST_RATE_STRAP: assert property (st.in_reset && i_rst_n |=>
		o_ctrl.dig1_family == $past(st.s2.gp_pin[3]) || $past(i_wr))
		else $error("rate strap wrong");
	AST_LOSS_MODE: assert property (st.live && st.ic.ref_loss_mode |=>
		o_irq_pin.oe && o_irq_pin.out == $past(i_ref_activity))
		else $error("loss mode pin wrong");
	// Loss mode is always push-pull, so open drain is judged outside it
	AST_OPEN_DRAIN: assert property (st.live && st.ic.open_drain && !st.ic.ref_loss_mode |=>
		!o_irq_pin.out || !o_irq_pin.oe)
		else $error("open drain drove high");
	AST_STRAP_HOLD: assert property (st.live ##1 st.live |-> $stable(o_strap))
		else $error("strap changed after capture");

	COV_SPI_WRITE: cover property (st.spi == strap_pin_pkg::SPI_DATA && cap_edge && !st.rw
		&& st.bit_cnt == strap_pin_pkg::LAST_BIT);
	COV_SPI_READ_TRAIL: cover property (st.spi == strap_pin_pkg::SPI_DATA && launch_edge
		&& st.rw && st.s2.spi.capture_edge_select);
	COV_PAIR_TWO: cover property (o_input_pair_select);
	COV_OPEN_DRAIN_LOW: cover property (o_irq_pin.oe && st.ic.open_drain);

endmodule // strap_pin_block
